// ==== rtl/txdma_pkg.sv ====
package txdma_pkg;
    // Register byte addresses
    localparam logic [15:0] TX_DESC_CTL_ADDR = 16'h3828;
    localparam logic [15:0] TX_ABS_DELAY_ADDR = 16'h382c;
    localparam logic [15:0] TSO_PAD_MIN_ADDR = 16'h3830;
    localparam logic [15:0] TX_CAUSE_ADDR = 16'h3834;
    // Writable bit masks, reserved bits read as zero
    localparam logic [31:0] CTL_MASK = 32'hff3f3f3f;
    localparam logic [31:0] ABS_MASK = 32'h0000ffff;
    // Reset values
    localparam logic [31:0] CTL_RESET = 32'h00000000;
    localparam logic [31:0] ABS_RESET = 32'h00000000;
    localparam logic [31:0] TSO_RESET = 32'h01000400;
    // Field positions in the control register
    localparam int PTH_LSB = 0;
    localparam int HTH_LSB = 8;
    localparam int WTH_LSB = 16;
    localparam int UNIT_BIT = 24;
    localparam int LOW_LSB = 25;
    localparam int THR_W = 6;
    localparam int LOW_W = 7;
    // Field positions in the pad/minimum and cause registers
    localparam int MIN_LSB = 0;
    localparam int PAD_LSB = 16;
    localparam int CAUSE_LOW_BIT = 0;
    localparam int CAUSE_WB_BIT = 1;
    // Descriptor size and timer unit
    localparam int DESC_BYTES = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DELAY_UNIT_NS = 1024;
    localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;

    // One processed or transmitted descriptor from the transmit engine
    typedef struct packed {
        logic done;
        logic report;
        logic delay_en;
    } desc_event_t;

    // Data fetch request from the transmit engine
    typedef struct packed {
        logic valid;
        logic tso;
        logic new_desc;
        logic seg_start;
        logic [15:0] remaining;
        logic [15:0] pb_free;
        logic [15:0] seg_need;
    } fetch_req_t;
endpackage : txdma_pkg

// ==== rtl/tx_descriptor_dma_thresholds.sv ====
`timescale 1ns/1ps
`default_nettype none
module tx_descriptor_dma_thresholds #(
    parameter int CACHE_LINE_DESC = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [6:0] cache_count,
    input wire logic [15:0] host_avail,
    input wire logic [15:0] pending_count,
    input wire txdma_pkg::desc_event_t processed,
    input wire txdma_pkg::desc_event_t sent,
    input wire logic burst_wb_en,
    input wire logic flush,
    input wire logic rel_expired,
    input wire txdma_pkg::fetch_req_t fetch,
    output logic prefetch_req,
    output logic wb_req,
    output logic [7:0] wb_count,
    output logic grant,
    output logic [15:0] grant_len,
    output logic hdr_insert,
    output logic desc_low_cause,
    output logic tx_written_back_cause
);
    logic [31:0] ctl_reg;
    logic [31:0] abs_reg;
    logic [31:0] tso_reg;
    logic ack_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wr_en;
    logic [6:0] cache_prev_reg;
    logic [15:0] pend_prev_reg;
    logic [1:0] cause_reg;
    logic low_hit;
    logic imm_irq;
    logic timer_run_reg;
    logic [15:0] timer_reg;
    logic [6:0] tick_cnt_reg;
    logic tick;
    logic expire;
    logic armed_reg;
    logic [7:0] wb_cnt_reg;
    logic wb_req_reg;
    logic pf_reg;
    logic grant_reg;
    logic [15:0] grant_len_reg;
    logic hdr_reg;
    logic [15:0] pad;
    logic [15:0] min_xfer;
    logic [15:0] room;
    logic fetch_ok;
    logic [15:0] fetch_len;

    // Scale a threshold field to descriptors
    function automatic logic [15:0] to_desc(input logic [5:0] v,
                                            input logic unit_sel);
        if (unit_sel) begin
            to_desc = {10'h000, v};
        end else begin
            to_desc = 16'(int'(v) * CACHE_LINE_DESC);
        end
    endfunction : to_desc

    // Bus answer: one wait cycle, then a single ready cycle
    assign wr_en = avs_write && ack_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            wait_reg <= 1'b1;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
            wait_reg <= !((avs_read || avs_write) && !ack_reg);
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (avs_address)
            txdma_pkg::TX_DESC_CTL_ADDR: rdata_next = ctl_reg;
            txdma_pkg::TX_ABS_DELAY_ADDR: rdata_next = abs_reg;
            txdma_pkg::TSO_PAD_MIN_ADDR: rdata_next = tso_reg;
            txdma_pkg::TX_CAUSE_ADDR: rdata_next = {30'h0, cause_reg};
            default: rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_reg <= 32'h0;
        end else if (avs_read && !ack_reg) begin
            rdata_reg <= rdata_next;
        end
    end

    // Configuration registers; unmapped writes are dropped
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl_reg <= txdma_pkg::CTL_RESET;
            abs_reg <= txdma_pkg::ABS_RESET;
            tso_reg <= txdma_pkg::TSO_RESET;
        end else if (wr_en) begin
            if (avs_address == txdma_pkg::TX_DESC_CTL_ADDR) begin
                ctl_reg <= avs_writedata & txdma_pkg::CTL_MASK;
            end
            if (avs_address == txdma_pkg::TX_ABS_DELAY_ADDR) begin
                abs_reg <= avs_writedata & txdma_pkg::ABS_MASK;
            end
            if (avs_address == txdma_pkg::TSO_PAD_MIN_ADDR) begin
                tso_reg <= avs_writedata;
            end
        end
    end

    // Descriptor-low detection on the falling step of the counts
    always_ff @(posedge mclk) begin
        if (rst) begin
            cache_prev_reg <= 7'h0;
            pend_prev_reg <= 16'h0;
        end else begin
            cache_prev_reg <= cache_count;
            pend_prev_reg <= pending_count;
        end
    end

    always_comb begin
        if (ctl_reg[txdma_pkg::LOW_LSB +: txdma_pkg::LOW_W] == 7'h0) begin
            low_hit = cache_prev_reg != 7'h0 && cache_count == 7'h0;
        end else begin
            low_hit = pend_prev_reg ==
                {6'h0, ctl_reg[txdma_pkg::LOW_LSB +: txdma_pkg::LOW_W],
                 3'h1} && pending_count ==
                {6'h0, ctl_reg[txdma_pkg::LOW_LSB +: txdma_pkg::LOW_W],
                 3'h0};
        end
    end

    // Sticky cause bits, write one to clear; a new event beats the clear
    assign imm_irq = sent.done && sent.report && !sent.delay_en;
    always_ff @(posedge mclk) begin
        if (rst) begin
            cause_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wr_en && avs_address == txdma_pkg::TX_CAUSE_ADDR &&
                    avs_writedata[i]) begin
                    cause_reg[i] <= 1'b0;
                end
            end
            if (low_hit) begin
                cause_reg[txdma_pkg::CAUSE_LOW_BIT] <= 1'b1;
            end
            if (expire || imm_irq) begin
                cause_reg[txdma_pkg::CAUSE_WB_BIT] <= 1'b1;
            end
        end
    end

    // Delay-unit prescaler, free running
    assign tick = tick_cnt_reg == 7'(txdma_pkg::DELAY_UNIT_CYC - 1);
    always_ff @(posedge mclk) begin
        if (rst || tick) begin
            tick_cnt_reg <= 7'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 7'h1;
        end
    end

    // Absolute countdown; not restarted while running, so the bound holds
    assign expire = timer_run_reg && tick && timer_reg == 16'h1;
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_run_reg <= 1'b0;
            timer_reg <= 16'h0;
        end else if (imm_irq || rel_expired || expire) begin
            timer_run_reg <= 1'b0;
        end else if (!timer_run_reg && sent.done && sent.report &&
                     sent.delay_en && abs_reg[15:0] != 16'h0) begin
            timer_run_reg <= 1'b1;
            timer_reg <= abs_reg[15:0];
        end else if (timer_run_reg && tick) begin
            timer_reg <= timer_reg - 16'h1;
        end
    end

    // Write-back accumulation, armed by a report-status descriptor
    always_ff @(posedge mclk) begin
        if (rst) begin
            armed_reg <= 1'b0;
            wb_cnt_reg <= 8'h0;
            wb_req_reg <= 1'b0;
        end else if (wb_req_reg) begin
            // A report descriptor in the request cycle starts the next batch
            wb_req_reg <= 1'b0;
            armed_reg <= processed.done && processed.report;
            wb_cnt_reg <= {7'h0, processed.done && processed.report};
        end else begin
            if (processed.done && (processed.report ||
                (burst_wb_en && armed_reg))) begin
                wb_cnt_reg <= wb_cnt_reg + 8'h1;
            end
            if (processed.done && processed.report) begin
                armed_reg <= 1'b1;
            end
            wb_req_reg <= wb_cnt_reg != 8'h0 && (flush ||
                16'(wb_cnt_reg) > to_desc(ctl_reg[txdma_pkg::WTH_LSB +:
                txdma_pkg::THR_W], ctl_reg[txdma_pkg::UNIT_BIT]));
        end
    end

    // Prefetch consideration against both thresholds
    always_ff @(posedge mclk) begin
        if (rst) begin
            pf_reg <= 1'b0;
        end else begin
            pf_reg <= 16'(cache_count) <
                to_desc(ctl_reg[txdma_pkg::PTH_LSB +: txdma_pkg::THR_W],
                        ctl_reg[txdma_pkg::UNIT_BIT]) &&
                host_avail >=
                to_desc(ctl_reg[txdma_pkg::HTH_LSB +: txdma_pkg::THR_W],
                        ctl_reg[txdma_pkg::UNIT_BIT]);
        end
    end

    // Fetch sizing against the packet buffer
    assign pad = tso_reg[txdma_pkg::PAD_LSB +: 16];
    assign min_xfer = tso_reg[txdma_pkg::MIN_LSB +: 16];
    assign room = fetch.pb_free > pad ? fetch.pb_free - pad : 16'h0;
    always_comb begin
        fetch_ok = 1'b0;
        fetch_len = 16'h0;
        if (!fetch.tso) begin
            fetch_ok = fetch.pb_free >= fetch.remaining;
            fetch_len = fetch.remaining;
        end else begin
            // Largest burst the room allows, kept clear of the pad
            fetch_len = room < fetch.remaining ? room
                                               : fetch.remaining;
            fetch_ok = fetch_len != 16'h0 &&
                (fetch.remaining < min_xfer ||
                 room >= min_xfer) &&
                (!fetch.new_desc || room >= fetch.seg_need);
        end
    end

    // One grant per request; the requester drops valid after it
    always_ff @(posedge mclk) begin
        if (rst) begin
            grant_reg <= 1'b0;
            grant_len_reg <= 16'h0;
            hdr_reg <= 1'b0;
        end else begin
            grant_reg <= fetch.valid && fetch_ok && !grant_reg;
            hdr_reg <= fetch.valid && fetch_ok && !grant_reg &&
                       fetch.tso && fetch.seg_start;
            if (fetch.valid && fetch_ok && !grant_reg) begin
                grant_len_reg <= fetch_len;
            end
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign prefetch_req = pf_reg;
    assign wb_req = wb_req_reg;
    assign wb_count = wb_cnt_reg;
    assign grant = grant_reg;
    assign grant_len = grant_len_reg;
    assign hdr_insert = hdr_reg;
    assign desc_low_cause = cause_reg[txdma_pkg::CAUSE_LOW_BIT];
    assign tx_written_back_cause = cause_reg[txdma_pkg::CAUSE_WB_BIT];

    // Checks on the block's own behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    AST_DESC_LOW: assert property (
        ctl_reg[31:25] != 7'h0 &&
        pend_prev_reg == {6'h0, ctl_reg[31:25], 3'h1} &&
        pending_count == {6'h0, ctl_reg[31:25], 3'h0}
        |=> desc_low_cause)
        else $error("descriptor-low step missed");
    AST_CACHE_EMPTY: assert property (
        ctl_reg[31:25] == 7'h0 && $past(cache_count) != 7'h0 &&
        cache_count == 7'h0 |=> desc_low_cause)
        else $error("empty cache did not raise cause");
    AST_NO_START: assert property (
        !timer_run_reg && !(sent.done && sent.report && sent.delay_en)
        |=> !timer_run_reg)
        else $error("timer started without both flags");
    AST_ZERO_OFF: assert property (
        !timer_run_reg && abs_reg[15:0] == 16'h0 |=> !timer_run_reg)
        else $error("timer ran with zero delay");
    AST_EXPIRY: assert property (
        expire |=> tx_written_back_cause && !timer_run_reg)
        else $error("expiry did not set cause");
    AST_STOP: assert property (
        rel_expired || imm_irq |=> !timer_run_reg)
        else $error("countdown not stopped");
    AST_IMMEDIATE: assert property (
        imm_irq |=> tx_written_back_cause)
        else $error("immediate interrupt missing");
    AST_WHOLE_FIT: assert property (
        grant && !$past(fetch.tso) |->
        $past(fetch.pb_free) >= grant_len)
        else $error("descriptor granted without room");
    AST_PAD_KEPT: assert property (
        grant && $past(fetch.tso) |->
        17'(grant_len) + 17'(pad) <= 17'($past(fetch.pb_free)))
        else $error("burst ate into pad");
    AST_MIN_XFER: assert property (
        grant && $past(fetch.tso) && $past(fetch.remaining) >= min_xfer
        |-> grant_len >= min_xfer)
        else $error("burst below minimum transfer");
    AST_WB_ZERO: assert property (
        ctl_reg[21:16] == 6'h0 && wb_cnt_reg != 8'h0 && !wb_req_reg
        |=> wb_req_reg)
        else $error("zero threshold write-back late");
    AST_BUS_ONE: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("ready held more than one cycle");

    COV_LOW: cover property (low_hit ##1 desc_low_cause);
    COV_EXPIRE: cover property (timer_run_reg ##[1:1000] expire);
    COV_TSO: cover property (grant && hdr_insert);
    COV_WB: cover property (processed.done ##[1:20] wb_req);
endmodule : tx_descriptor_dma_thresholds
`default_nettype wire

// ==== tb/fetch_requester.sv ====
`timescale 1ns/1ps
`default_nettype none
// Transmit engine side: raises fetch requests and holds them until granted or 12 edges pass
module fetch_requester (
    input wire logic mclk,
    input wire logic grant,
    output txdma_pkg::fetch_req_t fetch
);
    initial fetch = '0;

    // Holds valid and fields until grant is seen at an edge or 12 edges pass, then scrambles
    // the idle fields so a stale value can never pass for a live request
    task issue(input txdma_pkg::fetch_req_t r, output logic got);
        txdma_pkg::fetch_req_t idle;
        int n;
        idle = ~r;
        idle.valid = 1'b0;
        got = 1'b0;
        n = 0;
        fetch <= r;
        while (!got && n < 12) begin
            @(posedge mclk);
            got = (grant === 1'b1);
            n++;
        end
        fetch <= idle;
        @(posedge mclk);
    endtask : issue
endmodule : fetch_requester
`default_nettype wire

// ==== tb/tx_descriptor_dma_thresholds_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tx_descriptor_dma_thresholds_tb;
    localparam int CL = 4;
    logic mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [15:0] avs_address = '0, host_avail = '0, pending_count = 16'd10;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic avs_waitrequest, burst_wb_en = 1'b0, flush = 1'b0;
    logic rel_expired = 1'b0, prefetch_req, wb_req, grant, hdr_insert;
    logic desc_low_cause, tx_written_back_cause, got;
    logic [6:0] cache_count = '0;
    logic [7:0] wb_count;
    logic [15:0] grant_len;
    txdma_pkg::desc_event_t processed = '0, sent = '0;
    txdma_pkg::fetch_req_t fetch;
    logic [31:0] rq[$], gq[$], wq[$];
    int fail_count = 0, check_count = 0;

    always #5 mclk = ~mclk;

    tx_descriptor_dma_thresholds #(.CACHE_LINE_DESC(CL)) i_dut (
        .mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cache_count(cache_count),
        .host_avail(host_avail), .pending_count(pending_count),
        .processed(processed), .sent(sent), .burst_wb_en(burst_wb_en),
        .flush(flush), .rel_expired(rel_expired), .fetch(fetch),
        .prefetch_req(prefetch_req), .wb_req(wb_req), .wb_count(wb_count),
        .grant(grant), .grant_len(grant_len), .hdr_insert(hdr_insert),
        .desc_low_cause(desc_low_cause),
        .tx_written_back_cause(tx_written_back_cause)
    );

    fetch_requester i_part (.mclk(mclk), .grant(grant), .fetch(fetch));

    task conclude;
        $display("Checks %0d, errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    // One Avalon transfer; a read notes its expected data for the monitor
    task bus(input logic w, input logic [15:0] a, input logic [31:0] d,
             input logic [31:0] e);
        int n;
        n = 0;
        if (!w) rq.push_back(e);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail_count++;
            conclude();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
        @(posedge mclk);
    endtask : bus

    task cause(input logic [31:0] e);
        bus(1'b0, txdma_pkg::TX_CAUSE_ADDR, '0, e);
    endtask : cause

    task clr;
        bus(1'b1, txdma_pkg::TX_CAUSE_ADDR, 32'h00000003, '0);
    endtask : clr

    // Pulses done on the processed (p=1) or sent (p=0) event port
    task ev(input logic p, input txdma_pkg::desc_event_t e);
        if (p) processed <= e;
        else sent <= e;
        @(posedge mclk);
        processed <= '0;
        sent <= '0;
        @(posedge mclk);
    endtask : ev

    task fx(input int t, input int nd, input int ss, input int rem,
            input int pf, input int need, input int ok, input int len,
            input int h);
        if (ok != 0) gq.push_back({15'h0, 1'(h), 16'(len)});
        i_part.issue({1'b1, 1'(t), 1'(nd), 1'(ss), 16'(rem), 16'(pf),
                      16'(need)}, got);
        chk({31'h0, got}, {31'h0, 1'(ok)});
    endtask : fx

    // Monitors pair each observed answer with the oldest note
    always @(posedge mclk) begin
        if (avs_read && avs_waitrequest === 1'b0)
            chk(avs_readdata, rq.size() ? rq.pop_front() : 32'hdeadbeef);
        if (grant === 1'b1)
            chk({15'h0, hdr_insert, grant_len},
                gq.size() ? gq.pop_front() : 32'hdeadbeef);
        if (wb_req === 1'b1)
            chk({24'h0, wb_count}, wq.size() ? wq.pop_front() : 32'hdeadbeef);
    end

    initial begin
        cyc(60000);
        fail_count++;
        conclude();
    end

    logic [31:0] pc[5] = '{32'h01000204, 32'h01000204, 32'h01000204,
                           32'h00000101, 32'h00000101};
    logic [6:0] pcc[5] = '{7'd3, 7'd3, 7'd4, 7'(CL - 1), 7'(CL - 1)};
    logic [15:0] pha[5] = '{16'd2, 16'd1, 16'd9, 16'(CL), 16'(CL - 1)};
    logic pex[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [15:0] tab[4] = '{16'd3, 16'd0, 16'd3, 16'd3};
    logic [2:0] tev[4] = '{3'b101, 3'b111, 3'b111, 3'b111};
    logic [15:0] ra[4] = '{txdma_pkg::TX_DESC_CTL_ADDR,
        txdma_pkg::TX_ABS_DELAY_ADDR, txdma_pkg::TSO_PAD_MIN_ADDR, 16'h3900};
    logic [31:0] rv[4] = '{txdma_pkg::CTL_RESET, txdma_pkg::ABS_RESET,
                           txdma_pkg::TSO_RESET, 32'h0};

    initial begin
        void'($urandom(32'h2038));
        cyc(12);
        rst <= 1'b0;
        @(posedge mclk);
        // Reset values, then unmapped place reads zero
        for (int i = 0; i < 4; i++)
            bus(1'b0, ra[i], '0, rv[i]);
        bus(1'b1, ra[0], 32'hffffffff, '0);
        bus(1'b0, ra[0], '0, txdma_pkg::CTL_MASK);
        bus(1'b1, ra[1], 32'hffffffff, '0);
        bus(1'b0, ra[1], '0, txdma_pkg::ABS_MASK);
        // Descriptor-low: fires on the step to 8L, not one above it
        bus(1'b1, ra[0], 32'h03000000, '0);
        clr();
        pending_count <= 16'd9;
        cyc(3);
        cause(32'h0);
        pending_count <= 16'd8;
        cyc(3);
        cause(32'h1);
        bus(1'b1, ra[0], 32'h01000000, '0);
        cache_count <= 7'd1;
        cyc(2);
        clr();
        cache_count <= 7'd0;
        cyc(3);
        cause(32'h1);
        chk({31'h0, desc_low_cause}, 32'h1);
        // Prefetch in descriptor and cache-line units
        pha[0] = 16'd2 + 16'($urandom % 50);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, ra[0], pc[i], '0);
            cache_count <= pcc[i];
            host_avail <= pha[i];
            cyc(3);
            chk({31'h0, prefetch_req}, {31'h0, pex[i]});
        end
        // Write-back counting, burst and flush
        ev(1'b1, 3'b100);
        wq.push_back(32'h1);
        ev(1'b1, 3'b110);
        cyc(3);
        bus(1'b1, ra[0], 32'h01020000, '0);
        burst_wb_en <= 1'b1;
        ev(1'b1, 3'b110);
        ev(1'b1, 3'b100);
        wq.push_back(32'h3);
        ev(1'b1, 3'b100);
        cyc(3);
        burst_wb_en <= 1'b0;
        ev(1'b1, 3'b110);
        wq.push_back(32'h1);
        flush <= 1'b1;
        cyc(1);
        flush <= 1'b0;
        cyc(3);
        // Absolute delay expiry, not early
        bus(1'b1, ra[1], 32'h3, '0);
        clr();
        ev(1'b0, 3'b111);
        cyc(90);
        cause(32'h0);
        for (int n = 0; n < 400 && tx_written_back_cause !== 1'b1; n++) cyc(1);
        chk({31'h0, tx_written_back_cause}, 32'h1);
        // No start, disabled, and stopped by immediate or relative expiry
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ra[1], {16'h0, tab[i]}, '0);
            clr();
            ev(1'b0, tev[i]);
            cyc(10);
            if (i == 2) ev(1'b0, 3'b110);
            if (i == 2) cause(32'h2);
            if (i == 3) rel_expired <= 1'b1;
            cyc(1);
            rel_expired <= 1'b0;
            clr();
            cyc(400);
            cause(32'h0);
        end
        // Packet buffer admission; buffer sizes fall both above and below min+pad
        fx(0, 0, 0, 16'h200, 16'h800, 0, 1, 16'h200, 0);
        fx(0, 0, 0, 16'h900, 16'h800, 0, 0, 0, 0);
        fx(1, 0, 1, 16'h2000, 16'h900, 0, 1, 16'h800, 1);
        fx(1, 0, 0, 16'h2000, 16'h400, 0, 0, 0, 0);
        fx(1, 0, 0, 16'h200, 16'h400, 0, 1, 16'h200, 0);
        fx(1, 1, 1, 16'h2000, 16'h600, 16'h600, 0, 0, 0);
        fx(1, 1, 1, 16'h2000, 16'h600, 16'h500, 1, 16'h500, 1);
        // Smaller pad, same minimum: the TSO burst grows into the freed room
        bus(1'b1, ra[2], 32'h00800400, '0);
        bus(1'b0, ra[2], '0, 32'h00800400);
        fx(1, 0, 0, 16'h2000, 16'h900, 0, 1, 16'h880, 0);
        cyc(5);
        chk(rq.size() + gq.size() + wq.size(), 32'h0);
        conclude();
    end
endmodule : tx_descriptor_dma_thresholds_tb
`default_nettype wire
